// ### rtl/m_divider_adc_modclk_config.sv
// APB-mapped M-divider and ADC modulator clock divider configuration with divider ticks
//
// Implementation choice: the APB interface to the registers.
module m_divider_adc_modclk_config #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Values from the automatic clock detector
  input wire logic [5:0] auto_m_code_in,
  input wire logic [1:0] auto_adc_code_in,
  // Applied ratios and divider ticks
  output logic [6:0] m_ratio_out,
  output logic [2:0] adc_ratio_out,
  output logic m_tick_out,
  output logic adc_tick_out
);

  // ==========================================================
  // Parameter check; decode needs room for the highest own address
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 10 and 32");
  end

  typedef struct packed {
    logic [7:0] cfg;
    logic auto_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [6:0] m_ratio;
    logic [2:0] adc_ratio;
    logic written;
  } main_state_t;

  localparam main_state_t MAIN_RESET = '{
    cfg: clk_div_cfg_pkg::CFG_RESET,
    auto_en: clk_div_cfg_pkg::AUTO_RESET,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    m_ratio: clk_div_cfg_pkg::m_ratio_decode(clk_div_cfg_pkg::CFG_RESET[7:2]),
    adc_ratio: clk_div_cfg_pkg::adc_ratio_decode(clk_div_cfg_pkg::CFG_RESET[1:0]),
    written: 1'b0
  };

  main_state_t st;
  main_state_t next_st;
  logic access;
  logic hit_cfg;
  logic hit_auto;
  logic hit_status;
  logic [5:0] m_code;
  logic [1:0] adc_code;

  // ==========================================================
  // Address decode and field slices
  assign access = psel_in & penable_in;
  assign hit_cfg = paddr_in == ADDR_W'(clk_div_cfg_pkg::CFG_ADDR);
  assign hit_auto = paddr_in == ADDR_W'(clk_div_cfg_pkg::AUTO_ADDR);
  assign hit_status = paddr_in == ADDR_W'(clk_div_cfg_pkg::STATUS_ADDR);
  assign m_code = st.cfg[clk_div_cfg_pkg::M_LSB +: clk_div_cfg_pkg::M_WIDTH];
  assign adc_code = st.cfg[clk_div_cfg_pkg::ADC_LSB +: clk_div_cfg_pkg::ADC_WIDTH];

  // ==========================================================
  // Bus slave and ratio selection; one wait state keeps every output registered
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // First access cycle: prepare answer, raise pready next edge
    if (access && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !(hit_cfg || hit_auto || hit_status);
      next_st.prdata = 32'h0000_0000;
      if (hit_cfg) begin
        next_st.prdata[7:0] = st.cfg;
      end
      if (hit_auto) begin
        next_st.prdata[clk_div_cfg_pkg::AUTO_EN_BIT] = st.auto_en;
      end
      if (hit_status) begin
        next_st.prdata[clk_div_cfg_pkg::STATUS_M_LSB +: 7] = st.m_ratio;
        next_st.prdata[clk_div_cfg_pkg::STATUS_ADC_LSB +: 3] = st.adc_ratio;
      end
    end
    // Writes take effect only at the edge that completes the transfer
    if (access && st.pready && pwrite_in) begin
      if (hit_cfg) begin
        next_st.cfg = pwdata_in[7:0];
        next_st.written = 1'b1;
      end
      if (hit_auto) begin
        next_st.auto_en = pwdata_in[clk_div_cfg_pkg::AUTO_EN_BIT];
      end
    end
    if (st.auto_en) begin
      next_st.m_ratio = clk_div_cfg_pkg::m_ratio_decode(auto_m_code_in);
    end else begin
      next_st.m_ratio = clk_div_cfg_pkg::m_ratio_decode(m_code);
    end
    if (st.auto_en) begin
      next_st.adc_ratio = clk_div_cfg_pkg::adc_ratio_decode(auto_adc_code_in);
    end else begin
      next_st.adc_ratio = clk_div_cfg_pkg::adc_ratio_decode(adc_code);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= MAIN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Registered outputs
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign prdata_out = st.prdata;
  assign m_ratio_out = st.m_ratio;
  assign adc_ratio_out = st.adc_ratio;

  // ==========================================================
  // Dividers: ADC modulator stage counts ticks of the M stage
  ratio_divider #(
    .WIDTH(7)
  ) m_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(1'b1),
    .ratio_in(st.m_ratio),
    .tick_out(m_tick_out)
  );

  ratio_divider #(
    .WIDTH(3)
  ) adc_div (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(m_tick_out),
    .ratio_in(st.adc_ratio),
    .tick_out(adc_tick_out)
  );

  // ==========================================================
  // Checks
  // untouched register keeps reset value
  chk_cfg_reset_value: assert property (@(posedge clk_in) disable iff (rst_in)
    !st.written |-> st.cfg == clk_div_cfg_pkg::CFG_RESET)
    else $error("config register lost its reset value");

  chk_m_zero_code: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st.auto_en && m_code == 6'h00) |=> m_ratio_out == clk_div_cfg_pkg::M_ZERO_RATIO)
    else $error("M code zero did not divide by sixty-four");

  chk_m_code_ratio: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st.auto_en && m_code != 6'h00) |=> m_ratio_out == {1'b0, $past(m_code)})
    else $error("M ratio differs from programmed code");

  chk_m_auto_override: assert property (@(posedge clk_in) disable iff (rst_in)
    st.auto_en |=> m_ratio_out ==
      clk_div_cfg_pkg::m_ratio_decode($past(auto_m_code_in)))
    else $error("M ratio did not follow detector in auto mode");

  chk_adc_code_map: assert property (@(posedge clk_in) disable iff (rst_in)
    (!st.auto_en && adc_code != 2'h3) |=> adc_ratio_out == (3'h1 << $past(adc_code)))
    else $error("ADC divider ratio wrong for code");

  chk_adc_auto_override: assert property (@(posedge clk_in) disable iff (rst_in)
    st.auto_en |=> adc_ratio_out ==
      clk_div_cfg_pkg::adc_ratio_decode($past(auto_adc_code_in)))
    else $error("ADC ratio did not follow detector in auto mode");

  chk_apb_one_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    (access && !pready_out) |=> pready_out ##1 !pready_out)
    else $error("pready not a single pulse after one wait state");

  chk_apb_unmapped_err: assert property (@(posedge clk_in) disable iff (rst_in)
    (access && !pready_out && !(hit_cfg || hit_auto || hit_status)) |=> pslverr_out)
    else $error("unmapped access not flagged");

  chk_apb_mapped_ok: assert property (@(posedge clk_in) disable iff (rst_in)
    (access && !pready_out && (hit_cfg || hit_auto || hit_status)) |=> !pslverr_out)
    else $error("mapped access flagged as error");

  chk_cfg_write_lands: assert property (@(posedge clk_in) disable iff (rst_in)
    (access && pready_out && pwrite_in && hit_cfg) |=> st.cfg == $past(pwdata_in[7:0]))
    else $error("config write did not land");

  chk_m_tick_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    (m_tick_out && m_ratio_out != 7'd1) |=> !m_tick_out)
    else $error("M tick longer than one cycle");

  cov_cfg_write: cover property (@(posedge clk_in) disable iff (rst_in)
    access && pready_out && pwrite_in && hit_cfg);
  cov_auto_mode: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(st.auto_en));
  cov_adc_tick: cover property (@(posedge clk_in) disable iff (rst_in)
    adc_tick_out && adc_ratio_out == 3'h4);

endmodule : m_divider_adc_modclk_config

// ### rtl/clk_div_cfg_pkg.sv
// Register map, field layout, reset values and ratio decoding of the divider config block
package clk_div_cfg_pkg;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [9:0] CFG_INDEX = 10'h03a;
  localparam logic [9:0] AUTO_INDEX = 10'h050;
  localparam logic [9:0] STATUS_INDEX = 10'h051;
  localparam logic [11:0] CFG_ADDR = {CFG_INDEX, 2'b00};
  localparam logic [11:0] AUTO_ADDR = {AUTO_INDEX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

  // ==========================================================
  // Field layout and reset values
  localparam logic [7:0] CFG_RESET = 8'h04;
  localparam int M_LSB = 2;
  localparam int M_WIDTH = 6;
  localparam int ADC_LSB = 0;
  localparam int ADC_WIDTH = 2;
  localparam int AUTO_EN_BIT = 0;
  localparam int STATUS_M_LSB = 0;
  localparam int STATUS_ADC_LSB = 8;
  localparam logic AUTO_RESET = 1'b0;

  // ==========================================================
  // Ratios
  localparam logic [6:0] M_ZERO_RATIO = 7'h40;
  localparam logic [2:0] ADC_RATIO_1 = 3'h1;
  localparam logic [2:0] ADC_RATIO_2 = 3'h2;
  localparam logic [2:0] ADC_RATIO_4 = 3'h4;

  // Code zero stands for the full count of the six-bit field
  function automatic logic [6:0] m_ratio_decode(input logic [5:0] code);
    return (code == 6'h00) ? M_ZERO_RATIO : {1'b0, code};
  endfunction : m_ratio_decode

  // Reserved code three falls back to the largest legal ratio
  function automatic logic [2:0] adc_ratio_decode(input logic [1:0] code);
    logic [2:0] r;
    r = ADC_RATIO_4;
    unique case (code)
      2'h0: r = ADC_RATIO_1;
      2'h1: r = ADC_RATIO_2;
      2'h2: r = ADC_RATIO_4;
      2'h3: r = ADC_RATIO_4;
    endcase
    return r;
  endfunction : adc_ratio_decode

endpackage : clk_div_cfg_pkg

// ### rtl/ratio_divider.sv
// Programmable divider that emits one tick per ratio enabled input cycles
module ratio_divider #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic en_in,
  input wire logic [WIDTH-1:0] ratio_in,
  // Result
  output logic tick_out
);

  // ==========================================================
  // Parameter check; a one-bit count cannot hold any ratio above one
  if (WIDTH < 2) begin : g_width_check
    $error("ratio_divider WIDTH must be at least 2");
  end

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } div_state_t;

  localparam div_state_t DIV_RESET = '{count: '0, tick: 1'b0};

  div_state_t st;
  div_state_t next_st;
  logic [WIDTH-1:0] last;

  // Ratio of zero is never fed; treated as one to stay safe
  assign last = (ratio_in == '0) ? '0 : WIDTH'(ratio_in - 1'b1);

  // ==========================================================
  // Count enabled cycles; a ratio change lands at the latest on the next wrap
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (en_in) begin
      if (st.count >= last) begin
        next_st.count = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = WIDTH'(st.count + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= DIV_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.tick;

endmodule : ratio_divider

// ### tb/m_divider_adc_modclk_config_tb.sv
// Self-checking bench for the M-divider and ADC modulator clock divider config block
module m_divider_adc_modclk_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Stimulus and observed signals
  logic clk_in, rst_in, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_out, rd;
  logic pready_out, pslverr_out, err;
  logic [5:0] auto_m;
  logic [1:0] auto_adc;
  logic [6:0] m_ratio_out;
  logic [2:0] adc_ratio_out;
  logic m_tick_out, adc_tick_out;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  m_divider_adc_modclk_config i_m_divider_adc_modclk_config (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .auto_m_code_in(auto_m), .auto_adc_code_in(auto_adc),
    .m_ratio_out(m_ratio_out), .adc_ratio_out(adc_ratio_out),
    .m_tick_out(m_tick_out), .adc_tick_out(adc_tick_out)
  );

  // ==========================================================
  // 125 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; ready and the answer are taken at the rising edge that ends it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Clocks between ticks; first two gaps skipped since a new ratio acts at the wrap
  task automatic period(input bit adc);
    repeat (2) begin
      n = 0;
      do @(negedge clk_in); while ((adc ? adc_tick_out : m_tick_out) !== 1'b1);
      do begin
        @(negedge clk_in);
        n++;
      end while ((adc ? adc_tick_out : m_tick_out) !== 1'b1);
    end
  endtask : period

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Test sequence
  initial begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    auto_m = 6'h00;
    auto_adc = 2'h0;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, clk_div_cfg_pkg::CFG_ADDR, 32'h0);
    check(rd, 32'h0000_0004);
    check({25'h0, m_ratio_out}, 32'h1);
    check({29'h0, adc_ratio_out}, 32'h1);
    $display("test reset value done");
    // Every M code, ADC codes zero to two in turn; code three is never written
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, clk_div_cfg_pkg::CFG_ADDR, {24'h0, i[5:0], 2'(i % 3)});
      apb(1'b0, clk_div_cfg_pkg::CFG_ADDR, 32'h0);
      check(rd, {24'h0, i[5:0], 2'(i % 3)});
      @(negedge clk_in);
      check({25'h0, m_ratio_out}, (i == 0) ? 32'd64 : i);
      check({29'h0, adc_ratio_out}, 32'd1 << (i % 3));
    end
    $display("test ratio decode done");
    // Detector values win while auto detection is on; detector code three acts as four
    @(posedge clk_in);
    auto_adc <= 2'h3;
    apb(1'b1, clk_div_cfg_pkg::AUTO_ADDR, 32'h1);
    apb(1'b1, clk_div_cfg_pkg::CFG_ADDR, {24'h0, 6'h07, 2'h1});
    @(negedge clk_in);
    check({25'h0, m_ratio_out}, 32'd64);
    check({29'h0, adc_ratio_out}, 32'd4);
    @(posedge clk_in);
    auto_m <= 6'h2a;
    auto_adc <= 2'h0;
    repeat (3) @(negedge clk_in);
    check({25'h0, m_ratio_out}, 32'd42);
    check({29'h0, adc_ratio_out}, 32'd1);
    apb(1'b0, clk_div_cfg_pkg::AUTO_ADDR, 32'h0);
    check(rd, 32'h1);
    check({31'h0, err}, 32'h0);
    apb(1'b0, clk_div_cfg_pkg::STATUS_ADDR, 32'h0);
    check(rd, {21'h0, 3'd1, 1'b0, 7'd42});
    apb(1'b0, clk_div_cfg_pkg::CFG_ADDR, 32'h0);
    check(rd, {24'h0, 6'h07, 2'h1});
    apb(1'b1, clk_div_cfg_pkg::AUTO_ADDR, 32'h0);
    // Ratio follows the cleared enable one edge after it lands
    repeat (2) @(negedge clk_in);
    check({25'h0, m_ratio_out}, 32'd7);
    check({29'h0, adc_ratio_out}, 32'd2);
    $display("test auto detection done");
    // Unmapped address is refused and leaves the config alone
    apb(1'b1, 12'h004, 32'hff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, clk_div_cfg_pkg::CFG_ADDR, 32'h0);
    check(rd, {24'h0, 6'h07, 2'h1});
    $display("test unmapped address done");
    // Tick spacing at the boundary code zero and a small code
    apb(1'b1, clk_div_cfg_pkg::CFG_ADDR, {24'h0, 6'h05, 2'h1});
    period(1'b0);
    check(n, 32'd5);
    period(1'b1);
    check(n, 32'd10);
    apb(1'b1, clk_div_cfg_pkg::CFG_ADDR, {24'h0, 6'h00, 2'h2});
    period(1'b0);
    check(n, 32'd64);
    period(1'b1);
    check(n, 32'd256);
    $display("test tick spacing done");
    results();
  end

endmodule : m_divider_adc_modclk_config_tb
